// ---- pkg/timer_chan_pkg.sv ----
// constants, types and helpers for the timer channel enable/prescale block
// assumes a 32-bit AXI4-Lite register port with byte addresses
package timer_chan_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int NCH    = 4;
  localparam int NCOMP  = 3;

  // register byte addresses
  localparam logic [7:0] OFF_DIR   = 8'h00;
  localparam logic [7:0] OFF_PROT  = 8'h04;
  localparam logic [7:0] OFF_ENPOL = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_PSC   = 8'h28;
  localparam logic [7:0] OFF_CAP1  = 8'h34;
  localparam logic [7:0] OFF_CAP2  = 8'h38;
  localparam logic [7:0] OFF_CAP3  = 8'h3c;
  localparam logic [7:0] OFF_CAP4  = 8'h40;

  // channel_enable_polarity field layout
  localparam int GRP_STRIDE = 4;
  localparam int BIT_EN     = 0;
  localparam int BIT_POL    = 1;
  localparam int BIT_NEN    = 2;
  localparam int BIT_NPOL   = 3;
  localparam int DIR_STRIDE = 2;

  localparam logic [15:0] ENPOL_RW_MASK = 16'h3fff;
  localparam logic [15:0] POL_MASK      = 16'h2aaa;
  localparam logic [15:0] ENPOL_RST     = 16'h0000;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] PSC_RST       = 16'h0000;
  localparam logic [7:0]  DIR_RST       = 8'h00;
  localparam logic [1:0]  PROT_RST      = 2'h0;

  localparam logic [1:0] DIR_OUTPUT  = 2'h0;
  localparam logic [1:0] LOCK_MIN    = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    W_ADDR = 2'b01,
    W_RESP = 2'b10
  } wst_t;

  typedef enum logic [1:0] {
    R_ADDR = 2'b01,
    R_DATA = 2'b10
  } rst_t;

  // byte-lane merge of the low half-word
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) r[7:0] = new_v[7:0];
    if (strb[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction : merge16

endpackage : timer_chan_pkg

// ---- src/count_prescaler.sv ----
// prescaler and 16-bit up counter with direct software load
// assumes load pulses come from the register slave in the same clock
`timescale 1ns/1ns
module count_prescaler
  import timer_chan_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] psc,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output      logic [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] pre;
    logic [W-1:0] cnt;
  } cst_t;

  cst_t s_r;
  cst_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // divide by psc+1
    if (s_r.pre >= psc) begin // [RULE_10]
      s_nxt.pre = '0;
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 1'b1;
    end
    if (load) begin
      s_nxt.cnt = load_val; // [RULE_11]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_CNT_STEP: assert property ( // [RULE_10]
    (!load && s_r.pre >= psc) |=> (count == $past(count) + 1'b1))
    else $error("counter did not step at prescaler wrap");

  AST_CNT_HOLD: assert property ( // [RULE_10]
    (!load && s_r.pre < psc) |=> (count == $past(count)))
    else $error("counter moved between prescaler wraps");

  AST_CNT_LOAD: assert property ( // [RULE_11]
    load |=> (count == $past(load_val)))
    else $error("counter not loaded with written value");

endmodule : count_prescaler

// ---- src/timer_channel_enable_prescale.sv ----
// channel enable/polarity control, capture path, counter and prescaler
// assumes AXI4-Lite master on the register port; inputs synchronous to CLOCK
`timescale 1ns/1ns
// Function
// RULE_01: enable bit gates output of output channel
// RULE_02: enable bit gates capture on input channel
// RULE_03: polarity bit 1 makes compare output low-active
// RULE_04: input polarity picks capture edge, trigger inversion
// RULE_05: protection level 2 or 3 locks polarity bits
// RULE_06: bit 2 enables channel 1 complementary output
// RULE_07: bit 3 sets complementary output active level
// RULE_08: channels 2, 3 repeat group at 4, 8
// RULE_09: channel 4 has enable, polarity only; 15:14 reserved
// RULE_10: counter clock is input divided by prescaler+1
// RULE_11: counter reads current count, write loads it
// RULE_12: direction 00 output; change only while disabled
module timer_channel_enable_prescale
  import timer_chan_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output      logic              AWREADY,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output      logic              WREADY,
  output      logic [1:0]        BRESP,
  output      logic              BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output      logic              ARREADY,
  output      logic [DATA_W-1:0] RDATA,
  output      logic [1:0]        RRESP,
  output      logic              RVALID,
  input  wire logic              RREADY,
  input  wire logic [NCH-1:0]    OC_REF,
  input  wire logic [NCH-1:0]    CH_IN,
  output      logic [NCH-1:0]    CH_OUT,
  output      logic [NCH-1:0]    CH_OE_N,
  output      logic [NCOMP-1:0]  CHN_OUT,
  output      logic [NCOMP-1:0]  CHN_OE_N,
  output      logic [NCH-1:0]    TRIG_OUT,
  output      logic [CNT_W-1:0]  COUNT_VALUE
);

  typedef struct packed {
    wst_t                       wst;
    logic [ADDR_W-1:0]          awaddr;
    logic                       aw_got;
    logic [DATA_W-1:0]          wdata;
    logic [3:0]                 wstrb;
    logic                       w_got;
    logic [1:0]                 bresp;
    rst_t                       rst;
    logic [DATA_W-1:0]          rdata;
    logic [1:0]                 rresp;
    logic [15:0]                enpol;
    logic [7:0]                 dir;
    logic [1:0]                 prot;
    logic [15:0]                psc;
    logic [NCH-1:0]             in_prev;
    logic [NCH-1:0][CNT_W-1:0]  cap;
    logic [NCH-1:0]             out_pin;
    logic [NCH-1:0]             oe_n;
    logic [NCOMP-1:0]           outn_pin;
    logic [NCOMP-1:0]           oen_n;
    logic [NCH-1:0]             trig;
  } st_t;

  st_t               s_r;
  st_t               s_nxt;
  logic              aw_fire;
  logic              w_fire;
  logic              do_wr;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdat;
  logic [3:0]        wstb;
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_load_val;
  logic [CNT_W-1:0]  count;
  logic [NCH-1:0]    is_out;
  logic [NCH-1:0]    en;
  logic [NCH-1:0]    pol;
  logic [NCH-1:0]    edge_hit;

  assign AWREADY = (s_r.wst == W_ADDR) && !s_r.aw_got;
  assign WREADY  = (s_r.wst == W_ADDR) && !s_r.w_got;
  assign BVALID  = (s_r.wst == W_RESP);
  assign BRESP   = s_r.bresp;
  assign ARREADY = (s_r.rst == R_ADDR);
  assign RVALID  = (s_r.rst == R_DATA);
  assign RDATA   = s_r.rdata;
  assign RRESP   = s_r.rresp;

  assign aw_fire = AWVALID && AWREADY;
  assign w_fire  = WVALID && WREADY;
  assign do_wr   = (s_r.wst == W_ADDR) && (s_r.aw_got || aw_fire)
                   && (s_r.w_got || w_fire);
  assign waddr   = s_r.aw_got ? s_r.awaddr : AWADDR;
  assign wdat    = s_r.w_got ? s_r.wdata : WDATA;
  assign wstb    = s_r.w_got ? s_r.wstrb : WSTRB;

  assign cnt_load     = do_wr && (waddr == OFF_COUNT);
  assign cnt_load_val = merge16(count, wdat, wstb); // [RULE_11]

  // per-channel decode of the enable group
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      is_out[i] = (s_r.dir[DIR_STRIDE*i +: DIR_STRIDE] == DIR_OUTPUT); // [RULE_12]
      en[i]     = s_r.enpol[GRP_STRIDE*i + BIT_EN]; // [RULE_08]
      pol[i]    = s_r.enpol[GRP_STRIDE*i + BIT_POL]; // [RULE_08]
      // rising edge, or falling edge when inverted
      edge_hit[i] = pol[i] ? (s_r.in_prev[i] && !CH_IN[i])
                           : (!s_r.in_prev[i] && CH_IN[i]); // [RULE_04]
    end
  end

  always_comb begin
    logic [15:0] tmp;
    logic [15:0] keep;
    logic [7:0]  dnew;
    tmp   = '0;
    keep  = '0;
    dnew  = '0;
    s_nxt = s_r;

    // write channels
    if (aw_fire) begin
      s_nxt.awaddr = AWADDR;
      s_nxt.aw_got = 1'b1;
    end
    if (w_fire) begin
      s_nxt.wdata = WDATA;
      s_nxt.wstrb = WSTRB;
      s_nxt.w_got = 1'b1;
    end
    case (s_r.wst)
      W_ADDR: begin
        if (do_wr) begin
          s_nxt.wst    = W_RESP;
          s_nxt.aw_got = 1'b0;
          s_nxt.w_got  = 1'b0;
          s_nxt.bresp  = RESP_OKAY;
          case (waddr)
            OFF_ENPOL: begin
              tmp  = merge16(s_r.enpol, wdat, wstb);
              keep = (s_r.prot >= LOCK_MIN) ? POL_MASK : '0; // [RULE_05]
              s_nxt.enpol = ((tmp & ~keep) | (s_r.enpol & keep))
                            & ENPOL_RW_MASK; // [RULE_09]
            end
            OFF_DIR: begin
              tmp  = merge16({8'h00, s_r.dir}, wdat, wstb);
              dnew = tmp[7:0];
              for (int i = 0; i < NCH; i++) begin
                if (!en[i]) begin // [RULE_12]
                  s_nxt.dir[DIR_STRIDE*i +: DIR_STRIDE] =
                    dnew[DIR_STRIDE*i +: DIR_STRIDE];
                end
              end
            end
            OFF_PROT: begin
              tmp = merge16({14'h0000, s_r.prot}, wdat, wstb);
              s_nxt.prot = tmp[1:0];
            end
            OFF_PSC: begin
              s_nxt.psc = merge16(s_r.psc, wdat, wstb); // [RULE_10]
            end
            OFF_COUNT: begin
              s_nxt.bresp = RESP_OKAY;
            end
            default: begin
              s_nxt.bresp = RESP_SLVERR;
            end
          endcase
        end
      end
      W_RESP: begin
        if (BREADY) begin
          s_nxt.wst = W_ADDR;
        end
      end
      default: begin
        s_nxt.wst = W_ADDR;
      end
    endcase

    // read channels
    case (s_r.rst)
      R_ADDR: begin
        if (ARVALID) begin
          s_nxt.rst   = R_DATA;
          s_nxt.rresp = RESP_OKAY;
          s_nxt.rdata = '0;
          case (ARADDR)
            OFF_ENPOL: s_nxt.rdata[15:0] = s_r.enpol;
            OFF_COUNT: s_nxt.rdata[CNT_W-1:0] = count; // [RULE_11]
            OFF_PSC:   s_nxt.rdata[15:0] = s_r.psc;
            OFF_DIR:   s_nxt.rdata[7:0] = s_r.dir;
            OFF_PROT:  s_nxt.rdata[1:0] = s_r.prot;
            OFF_CAP1:  s_nxt.rdata[CNT_W-1:0] = s_r.cap[0];
            OFF_CAP2:  s_nxt.rdata[CNT_W-1:0] = s_r.cap[1];
            OFF_CAP3:  s_nxt.rdata[CNT_W-1:0] = s_r.cap[2];
            OFF_CAP4:  s_nxt.rdata[CNT_W-1:0] = s_r.cap[3];
            default:   s_nxt.rresp = RESP_SLVERR;
          endcase
        end
      end
      R_DATA: begin
        if (RREADY) begin
          s_nxt.rst = R_ADDR;
        end
      end
      default: begin
        s_nxt.rst = R_ADDR;
      end
    endcase

    // channel paths
    s_nxt.in_prev = CH_IN;
    for (int i = 0; i < NCH; i++) begin
      if (!is_out[i] && en[i] && edge_hit[i]) begin // [RULE_02]
        s_nxt.cap[i] = count;
      end
      s_nxt.oe_n[i]    = !(is_out[i] && en[i]); // [RULE_01]
      s_nxt.out_pin[i] = (is_out[i] && en[i]) ? (OC_REF[i] ^ pol[i])
                                              : 1'b0; // [RULE_03]
      s_nxt.trig[i]    = CH_IN[i] ^ pol[i]; // [RULE_04]
    end
    for (int i = 0; i < NCOMP; i++) begin
      s_nxt.oen_n[i] = !(is_out[i]
                        && s_r.enpol[GRP_STRIDE*i + BIT_NEN]); // [RULE_06]
      s_nxt.outn_pin[i] = s_nxt.oen_n[i] ? 1'b0
                          : (!OC_REF[i] ^ s_r.enpol[GRP_STRIDE*i + BIT_NPOL]); // [RULE_07]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_r          <= '0;
      s_r.wst      <= W_ADDR;
      s_r.rst      <= R_ADDR;
      s_r.enpol    <= ENPOL_RST;
      s_r.dir      <= DIR_RST;
      s_r.prot     <= PROT_RST;
      s_r.psc      <= PSC_RST;
      s_r.oe_n     <= '1;
      s_r.oen_n    <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  count_prescaler #(
    .W        (CNT_W)
  ) u_count (
    .clock    (CLOCK),
    .rst      (RST),
    .psc      (s_r.psc),
    .load     (cnt_load),
    .load_val (cnt_load_val),
    .count    (count)
  );

  assign CH_OUT      = s_r.out_pin;
  assign CH_OE_N     = s_r.oe_n;
  assign CHN_OUT     = s_r.outn_pin;
  assign CHN_OE_N    = s_r.oen_n;
  assign TRIG_OUT    = s_r.trig;
  assign COUNT_VALUE = count;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence ch0_fall_armed;
    !is_out[0] && en[0] && pol[0] && s_r.in_prev[0] && !CH_IN[0];
  endsequence

  sequence ch0_rise_inverted;
    pol[0] && !s_r.in_prev[0] && CH_IN[0];
  endsequence

  AST_OUT_GATED: assert property ( // [RULE_01]
    (is_out[0] && !en[0]) |=> (CH_OE_N[0] && !CH_OUT[0]))
    else $error("disabled output channel drives its pin");

  AST_CAP_BLOCKED: assert property ( // [RULE_02]
    (!is_out[1] && !en[1]) |=> (s_r.cap[1] == $past(s_r.cap[1])))
    else $error("capture register changed while capture disabled");

  AST_OUT_LOW_ACTIVE: assert property ( // [RULE_03]
    (is_out[2] && en[2] && pol[2]) |=> (CH_OUT[2] == !$past(OC_REF[2])))
    else $error("inverted compare output not low-active");

  AST_CAP_FALL: assert property ( // [RULE_04]
    ch0_fall_armed |=> (s_r.cap[0] == $past(count)))
    else $error("falling edge did not capture count");

  AST_NO_CAP_RISE_INV: assert property ( // [RULE_04]
    ch0_rise_inverted |=> (s_r.cap[0] == $past(s_r.cap[0])))
    else $error("rising edge captured while inverted");

  AST_POL_LOCK: assert property ( // [RULE_05]
    (do_wr && waddr == OFF_ENPOL && s_r.prot >= LOCK_MIN)
    |=> (((s_r.enpol ^ $past(s_r.enpol)) & POL_MASK) == 16'h0000))
    else $error("polarity bit changed under write protection");

  AST_COMP_OUT: assert property ( // [RULE_06] [RULE_07]
    (is_out[0] && s_r.enpol[BIT_NEN] && s_r.enpol[BIT_NPOL])
    |=> (!CHN_OE_N[0] && CHN_OUT[0] == $past(OC_REF[0])))
    else $error("complementary output level or enable wrong");

  AST_RESERVED: assert property ( // [RULE_09]
    (s_r.enpol & ~ENPOL_RW_MASK) == 16'h0000)
    else $error("reserved enable bits set");

  AST_DIR_LOCKED: assert property ( // [RULE_12]
    $changed(s_r.dir[1:0]) |-> !$past(en[0]))
    else $error("direction changed while channel enabled");

  sequence ch3_rise_armed;
    !is_out[3] && en[3] && !pol[3] && !s_r.in_prev[3] && CH_IN[3];
  endsequence

  AST_CAP_RISE: assert property ( // [RULE_04]
    ch3_rise_armed |=> (s_r.cap[3] == $past(count)))
    else $error("rising edge did not capture count");

  AST_OUT_HIGH_ACTIVE: assert property ( // [RULE_03]
    (is_out[1] && en[1] && !pol[1]) |=> (CH_OUT[1] == $past(OC_REF[1])))
    else $error("compare output not high-active");

  AST_COMP_OFF: assert property ( // [RULE_06]
    (is_out[1] && !s_r.enpol[GRP_STRIDE + BIT_NEN]) |=> (CHN_OE_N[1] && !CHN_OUT[1]))
    else $error("disabled complementary output drives its pin");

  AST_TRIG_POL: assert property ( // [RULE_04]
    1'b1 |=> (TRIG_OUT == ($past(CH_IN) ^ $past(pol))))
    else $error("trigger output polarity wrong");

  AST_PSC_LOAD: assert property ( // [RULE_10]
    (do_wr && waddr == OFF_PSC && &wstb[1:0]) |=> (s_r.psc == $past(wdat[15:0])))
    else $error("divider not loaded with written value");

endmodule : timer_channel_enable_prescale

// ---- verification/pin_partner.sv ----
// pad model for the channel pins: block drive first, else the outside source
// assumes block pin outputs are registered on clock; outside source set by the bench
`timescale 1ns/1ns
module pin_partner
  import timer_chan_pkg::*;
(
  input  wire logic           clock,
  input  wire logic [NCH-1:0] ch_out,
  input  wire logic [NCH-1:0] ch_oe_n,
  input  wire logic [NCH-1:0] ext_val,
  input  wire logic [NCH-1:0] ext_on,
  output      logic [NCH-1:0] pad
);
  logic [NCH-1:0] last_r;

  // undriven pad shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pad[i] = !ch_oe_n[i] ? ch_out[i] : (ext_on[i] ? ext_val[i] : ~last_r[i]);
    end
  end

  always_ff @(posedge clock) begin
    last_r <= pad;
  end
endmodule : pin_partner

// ---- verification/test_timer_channel_enable_prescale.sv ----
// self-checking bench: register bus, pin gating, protection, capture, prescaler
// assumes pin_partner model and the timer_chan_pkg constants
`timescale 1ns/1ns
module test_timer_channel_enable_prescale;
  import timer_chan_pkg::*;
  localparam logic [15:0] PLV [4] = '{16'h0002, 16'h0001, 16'h0003, 16'h0000};
  localparam logic [15:0] PWD [4] = '{16'h3fff, 16'h3fff, 16'h0000, 16'h0000};
  localparam logic [15:0] PEX [4] = '{16'h1555, 16'h3fff, 16'h2aaa, 16'h0000};
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [3:0] ocref = '0, ext_val = '0, ch_in;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ch_out, ch_oe_n, trig_out;
  logic [2:0] chn_out, chn_oe_n;
  logic [15:0] count_value;
  int error_cnt = 0, cmp_count = 0, cyc = 0;

  always #50 clk = ~clk;

  timer_channel_enable_prescale u_timer_channel_enable_prescale (
    .CLOCK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'h3), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .OC_REF(ocref), .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE_N(ch_oe_n),
    .CHN_OUT(chn_out), .CHN_OE_N(chn_oe_n), .TRIG_OUT(trig_out),
    .COUNT_VALUE(count_value));

  pin_partner u_pin_partner (.clock(clk), .ch_out(ch_out), .ch_oe_n(ch_oe_n),
    .ext_val(ext_val), .ext_on(4'hf), .pad(ch_in));

  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t timeout", $time);
      final_report();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s resp %h exp %h", $time, s, got, exp);
    end
  endtask : chk_resp

  // bus cycles, entered just after a rising edge
  task automatic axw(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata[15:0];
        r = rresp;
        break;
      end
    end
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk_resp(r, RESP_OKAY, "write");
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk_resp(r, RESP_OKAY, "read");
    chk_val(32'(d), 32'(e), "read data");
  endtask : rdc

  // expected {chn_oe_n, chn_out, ch_oe_n, ch_out} with every channel an output
  function automatic logic [13:0] pins(input logic [15:0] ep, input logic [3:0] oref);
    logic [13:0] p;
    for (int i = 0; i < 4; i++) begin
      p[i] = ep[4*i] & (oref[i] ^ ep[4*i+1]);
      p[4+i] = ~ep[4*i];
    end
    for (int i = 0; i < 3; i++) begin
      p[8+i] = ep[4*i+2] & (~oref[i] ^ ep[4*i+3]);
      p[11+i] = ~ep[4*i+2];
    end
    return p;
  endfunction : pins

  initial begin
    logic [15:0] d, ep, k, k2;
    logic [1:0] r;
    int p, t;
    void'($urandom(35524));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(OFF_ENPOL, ENPOL_RST);
    rdc(OFF_PSC, PSC_RST);
    axr(8'h10, d, r);
    chk_resp(r, RESP_SLVERR, "unmapped");
    // random output configurations and compare references
    for (int n = 0; n < 24; n++) begin
      ep = (n == 0) ? 16'hffff : 16'($urandom);
      ocref <= 4'($urandom);
      wr(OFF_ENPOL, ep);
      rdc(OFF_ENPOL, ep & ENPOL_RW_MASK);
      repeat (2) @(posedge clk);
      chk_val(32'({chn_oe_n, chn_out, ch_oe_n, ch_out}), 32'(pins(ep, ocref)), "pins");
    end
    // polarity lock by protection level
    wr(OFF_ENPOL, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_PROT, PLV[i]);
      wr(OFF_ENPOL, PWD[i]);
      rdc(OFF_ENPOL, PEX[i]);
    end
    // direction only changes while disabled
    wr(OFF_ENPOL, 16'h1111);
    wr(OFF_DIR, 16'h0079);
    rdc(OFF_DIR, 16'h0000);
    wr(OFF_ENPOL, 16'h0000);
    wr(OFF_DIR, 16'h0079);
    rdc(OFF_DIR, 16'h0079);
    // capture on selected edge, counter frozen by a large divider
    wr(OFF_PSC, 16'hffff);
    k = 16'($urandom);
    wr(OFF_COUNT, k);
    rdc(OFF_COUNT, k);
    wr(OFF_ENPOL, 16'h1303);
    ext_val <= 4'hf;
    repeat (3) @(posedge clk);
    chk_val(32'(trig_out), 32'h0000000a, "trigger");
    for (int i = 0; i < 4; i++) rdc(OFF_CAP1 + 8'(4*i), (i == 3) ? k : 16'h0000);
    k2 = ~k;
    wr(OFF_COUNT, k2);
    ext_val <= 4'h0;
    repeat (3) @(posedge clk);
    chk_val(32'(trig_out), 32'h00000005, "trigger");
    for (int i = 0; i < 4; i++) rdc(OFF_CAP1 + 8'(4*i), (i == 3) ? k : ((i == 1) ? 16'h0000 : k2));
    axw(OFF_CAP1, 16'h1234, r);
    chk_resp(r, RESP_SLVERR, "capture write");
    // step period equals divider plus one
    for (int n = 0; n < 5; n++) begin
      p = (n < 3) ? (n * n + n / 2) : (2 + ($urandom % 8));
      wr(OFF_PSC, 16'(p));
      k = count_value;
      while (count_value === k) @(posedge clk);
      k = count_value;
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (count_value === k);
      chk_val(32'(t), 32'(p + 1), "step period");
      chk_val(32'(count_value), 32'(16'(k + 16'h0001)), "step size");
    end
    final_report();
  end
endmodule : test_timer_channel_enable_prescale
